// ---- logic/link_irq_pkg.sv ----
package link_irq_pkg;

    // register widths and wishbone geometry
    localparam int REG_W  = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RXDATA  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h10;

    // field positions in enable, flag and pending layouts
    localparam int BIT_ARB_LOST = 7;
    localparam int BIT_RX_FULL  = 0;
    localparam int TX_HI        = 6;
    localparam int TX_LO        = 4;
    localparam int RX_HI        = 3;
    localparam int RX_LO        = 0;

    // reset values
    localparam logic [REG_W-1:0] RST_ENABLE = 8'h00;
    localparam logic [REG_W-1:0] RST_MASK   = 8'h00;
    localparam logic [REG_W-1:0] RST_ZERO   = 8'h00;

    // host service windows for a full receive buffer, in microseconds
    localparam int SERVICE_NORMAL_US = 500;
    localparam int SERVICE_QUAD_US   = 125;
    localparam int CLK_MHZ           = 25;
    localparam int SERVICE_NORMAL_CYC = SERVICE_NORMAL_US * CLK_MHZ;
    localparam int SERVICE_QUAD_CYC   = SERVICE_QUAD_US * CLK_MHZ;

    // wishbone request as seen by the slave
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    // wishbone answer
    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } wb_rsp_t;

    // events from the link engine, one-cycle pulses
    typedef struct packed {
        logic [REG_W-1:0] flagSet;
        logic             rxPost;
        logic [REG_W-1:0] rxByte;
        logic             dmaRead;
    } link_evt_t;

endpackage

// ---- logic/link_irq_gate.sv ----
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module link_irq_gate
(
    // clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    ce,
    // wishbone slave
    input  wire link_irq_pkg::wb_req_t   wbReq,
    output      link_irq_pkg::wb_rsp_t   wbRsp,
    // link engine events
    input  wire link_irq_pkg::link_evt_t linkEvt,
    input  wire logic                    quadRateMode,
    // interrupt requests
    output      logic                    txIrq,
    output      logic                    rxIrq,
    output      logic                    irq,
    output      logic [7:0]              serviceWindow
);
    import link_irq_pkg::*;

    // block overview, register side
    // - enable byte gates each event into the pending byte
    // - flag byte records every event, enabled or not
    // - pending byte records only events taken while enabled
    // - mask byte gates pending onto the single irq line
    // - rx data byte holds the last posted receive byte
    //
    // flag byte behaviour
    // - bit 0 is rx full, set by a posted byte
    // - bit 0 clears only by a buffer read or dma take
    // - bits 7..1 clear by writing a one to them
    // - a write of one to bit 0 is ignored on purpose
    //
    // pending byte behaviour
    // - sets from an event only if its enable was high
    //   at the very edge that takes the event
    // - an enable raised later never revives an old event
    // - clearing a flag clears its pending bit too
    // - pending can also be cleared by writing ones
    // - dropping an enable leaves pending untouched
    //
    // request outputs
    // - transmit request is the or of pending 7..4
    // - receive request is the or of pending 3..0
    // - flags never feed a request directly
    //
    // bus side
    // - classic single cycle, answered one clock later
    // - ack stands one cycle, then falls even if stb stays
    // - unmapped offsets answer, read zero, ignore writes
    // - only the low byte lane carries register data

    // all block state
    typedef struct packed {
        logic [REG_W-1:0]  enable;   // interrupt_enable_control
        logic [REG_W-1:0]  flags;    // interrupt_flag_status
        logic [REG_W-1:0]  pending;  // events caught while enabled
        logic [REG_W-1:0]  mask;     // gate onto irq
        logic [REG_W-1:0]  rxData;   // rx_data_buffer
        logic              ack;      // wishbone answer
        logic [DATA_W-1:0] rdat;     // read data
    } state_t;

    state_t state_r;  // registered state
    state_t state_nxt;  // next state

    logic              access;   // bus cycle taken this edge
    logic              wrLane0;  // write reaching low byte
    logic [REG_W-1:0]  wByte;    // written byte
    logic [REG_W-1:0]  clrFlag;  // flag clears this cycle
    logic [REG_W-1:0]  evt;      // flag set events
    logic [DATA_W-1:0] rd;       // read mux

    // next-state logic
    always_comb
    begin
        state_nxt = state_r;
        access    = wbReq.cyc && wbReq.stb && !state_r.ack;
        wrLane0   = access && wbReq.we && wbReq.sel[0];
        wByte     = wbReq.dat[REG_W-1:0];
        clrFlag   = RST_ZERO;
        evt       = linkEvt.flagSet;
        rd        = '0;

        // rx byte posting sets rx full
        if (linkEvt.rxPost)
        begin
            evt[BIT_RX_FULL] = 1'b1;
            state_nxt.rxData = linkEvt.rxByte;
        end

        // read mux, unmapped reads zero
        unique case (wbReq.adr)
            OFS_ENABLE:  rd[REG_W-1:0] = state_r.enable;
            OFS_FLAGS:   rd[REG_W-1:0] = state_r.flags;
            OFS_RXDATA:  rd[REG_W-1:0] = state_r.rxData;
            OFS_PENDING: rd[REG_W-1:0] = state_r.pending;
            OFS_MASK:    rd[REG_W-1:0] = state_r.mask;
            default:     rd = '0;
        endcase

        // rx full clears on cpu read or dma transfer
        if ((access && !wbReq.we && wbReq.adr == OFS_RXDATA) || linkEvt.dmaRead)
        begin
            clrFlag[BIT_RX_FULL] = 1'b1;
        end

        // register writes
        if (wrLane0)
        begin
            unique case (wbReq.adr)
                OFS_ENABLE:  state_nxt.enable = wByte;
                OFS_FLAGS:
                begin
                    // write one clears, rx full only by read or dma
                    clrFlag = clrFlag | (wByte & ~(REG_W'(1) << BIT_RX_FULL));
                end
                OFS_PENDING: state_nxt.pending = state_r.pending & ~wByte;
                OFS_MASK:    state_nxt.mask = wByte;
                default:     ;
            endcase
        end

        // flags set regardless of enable; set wins over clear
        state_nxt.flags = (state_r.flags & ~clrFlag) | evt;

        // pending drops with its flag, set only by enabled events
        state_nxt.pending = (state_nxt.pending & ~clrFlag)
                          | (evt & state_r.enable);

        // answer one cycle after request
        state_nxt.ack  = access;
        state_nxt.rdat = access ? rd : '0;
    end

    // state register
    // reset branch loads constants only
    // ce low freezes everything, ack included,
    // so a bus cycle simply waits while frozen
    // events arriving while frozen are not seen;
    // the link engine shares the same enable
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= '{enable: RST_ENABLE, flags: RST_ZERO, pending: RST_ZERO,
                         mask: RST_MASK, rxData: RST_ZERO, ack: 1'b0, rdat: '0};
        end
        else if (ce)
        begin
            state_r <= state_nxt;
        end
    end

    // outputs below, except serviceWindow which decodes the quadRateMode input, are plain decodes of registers,
    // so they settle right after each clock edge
    // and carry no glitch from bus inputs
    //
    // requests from pending, never from flags alone
    // bit 7 belongs to the transmit group with 6..4
    // bits 3..0 form the receive group, rx full at 0
    // irq is the masked union of both groups
    // and follows pending with no extra delay
    //
    // service window figure
    // - quad rate gives the short window directly
    // - normal rate does not fit eight bits, so it
    //   saturates to all ones; software treats that
    //   as the long window
    //
    // bus answer comes straight from registers
    assign txIrq = |state_r.pending[BIT_ARB_LOST:TX_LO];
    assign rxIrq = |state_r.pending[RX_HI:RX_LO];
    assign irq   = |(state_r.pending & state_r.mask);
    // service window figure for software, in microseconds
    assign serviceWindow = quadRateMode ? 8'(SERVICE_QUAD_US) : 8'hFF;
    assign wbRsp.ack = state_r.ack;
    assign wbRsp.dat = state_r.rdat;

endmodule // link_irq_gate

`default_nettype wire

// ---- tb/link_irq_gate_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module link_irq_gate_chk
    import link_irq_pkg::*;
(
    input wire logic clk, resetn, ce,
    input wire wb_req_t wbReq,
    input wire wb_rsp_t wbRsp,
    input wire link_evt_t linkEvt,
    input wire logic quadRateMode, txIrq, rxIrq, irq,
    input wire logic [7:0] serviceWindow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] en_r; // enable shadow
    // follow enable writes at the taking edge
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            en_r <= 8'h00;
        else if (ce && wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.sel[0] && wbReq.adr == OFS_ENABLE)
            en_r <= wbReq.dat[7:0];
    chk_arb_tx: assert property (ce && linkEvt.flagSet[7] && en_r[7] |=> txIrq) else $error("no tx req");
    chk_rx_full: assert property (ce && linkEvt.rxPost && en_r[0] |=> rxIrq) else $error("no rx req");
    chk_tx_gated: assert property (ce && !txIrq && (linkEvt.flagSet[7:4] & en_r[7:4]) == 4'h0 |=> !txIrq)
        else $error("stray tx req");
    chk_rx_gated: assert property (ce && !rxIrq && linkEvt.rxPost == 1'b0
        && (linkEvt.flagSet[3:0] & en_r[3:0]) == 4'h0 |=> !rxIrq) else $error("stray rx req");
    chk_irq_source: assert property (irq |-> txIrq || rxIrq) else $error("irq unsourced");
    chk_win_norm: assert property (!quadRateMode |-> serviceWindow == 8'hFF) else $error("bad window");
    chk_win_quad: assert property (quadRateMode |-> serviceWindow == 8'h7D) else $error("bad window");
    chk_ack_once: assert property (ce && wbRsp.ack |=> !wbRsp.ack) else $error("ack held");
endmodule // link_irq_gate_chk
bind link_irq_gate link_irq_gate_chk u_chk (.clk(clk), .resetn(resetn), .ce(ce), .wbReq(wbReq), .wbRsp(wbRsp),
    .linkEvt(linkEvt), .quadRateMode(quadRateMode), .txIrq(txIrq), .rxIrq(rxIrq), .irq(irq),
    .serviceWindow(serviceWindow));
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// host side: bus master and rx service
module host_model
    import link_irq_pkg::*;
(
    input  wire logic clk,
    output var  wb_req_t wbReq,
    input  wire wb_rsp_t wbRsp
);
    initial wbReq = '0;
    // one classic cycle held until ack
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        wbReq <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do @(posedge clk); while (wbRsp.ack !== 1'b1);
        q = wbRsp.dat;
        wbReq <= '0;
        @(posedge clk);
    endtask
    // read the rx buffer inside one byte time
    task automatic svc(input logic quad, output logic [31:0] q);
        repeat ($urandom % ((quad ? SERVICE_QUAD_CYC : SERVICE_NORMAL_CYC) / 16)) @(posedge clk);
        acc(1'b0, OFS_RXDATA, 32'h0, q);
    endtask
endmodule // host_model
`default_nettype wire

// ---- tb/test_link_irq_gate.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_link_irq_gate;
    import link_irq_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, quadRateMode = 1'b0;
    link_evt_t linkEvt = '0;
    wb_req_t wbReq;
    wb_rsp_t wbRsp;
    logic txIrq, rxIrq, irq;
    logic [7:0] serviceWindow, e, m, p, b;
    logic [31:0] q;
    int errors = 0, cmp_count = 0, ticks = 0, n;
    always #20 clk = ~clk;
    link_irq_gate u_dut (.clk(clk), .resetn(resetn), .ce(1'b1), .wbReq(wbReq), .wbRsp(wbRsp),
        .linkEvt(linkEvt), .quadRateMode(quadRateMode), .txIrq(txIrq), .rxIrq(rxIrq), .irq(irq),
        .serviceWindow(serviceWindow));
    host_model u_host (.clk(clk), .wbReq(wbReq), .wbRsp(wbRsp));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle event, then let it land
    task automatic ev(input link_evt_t v);
        linkEvt <= v;
        @(posedge clk);
        linkEvt <= '0;
        @(posedge clk);
    endtask
    // expected tx, rx, irq
    function automatic logic [2:0] want(logic [7:0] pe, logic [7:0] mk);
        return {|pe[7:4], |pe[3:0], |(pe & mk)};
    endfunction
    always @(posedge clk)
        if (++ticks > 40000)
        begin
            errors++;
            test_done();
        end
    initial
    begin
        void'($urandom(17));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 24; a += 4)
        begin
            u_host.acc(1'b0, 8'(a), 32'h0, q);
            chk(q, 32'h0);
        end
        for (int i = 0; i < 24; i++)
        begin
            e = 8'($urandom);
            m = 8'($urandom);
            b = 8'($urandom);
            n = $urandom % 8;
            quadRateMode <= 1'($urandom);
            u_host.acc(1'b1, OFS_ENABLE, {24'h0, e}, q);
            u_host.acc(1'b1, OFS_MASK, {24'h0, m}, q);
            if (n == 0)
                ev('{8'h00, 1'b1, b, 1'b0});
            else
                ev('{8'(1 << n), 1'b0, 8'h00, 1'b0});
            p = e & 8'(1 << n);
            chk({txIrq, rxIrq, irq}, want(p, m));
            chk(serviceWindow, quadRateMode ? 8'h7D : 8'hFF);
            u_host.acc(1'b0, OFS_FLAGS, 32'h0, q);
            chk(q, 32'(1 << n));
            u_host.acc(1'b0, OFS_PENDING, 32'h0, q);
            chk(q, {24'h0, p});
            u_host.acc(1'b0, OFS_MASK, 32'h0, q);
            chk(q, {24'h0, m});
            u_host.acc(1'b1, OFS_ENABLE, 32'hFF, q);
            chk({txIrq, rxIrq, irq}, want(p, m));
            if (n != 0)
                u_host.acc(1'b1, OFS_FLAGS, 32'hFE, q);
            else if (i % 2)
                ev('{8'h00, 1'b0, 8'h00, 1'b1});
            else
            begin
                u_host.svc(quadRateMode, q);
                chk(q, {24'h0, b});
            end
            chk({txIrq, rxIrq, irq}, 3'b000);
        end
        test_done();
    end
endmodule // test_link_irq_gate
`default_nettype wire
